// *** verilog/ihid_pkg.sv ***
// Shared constants, address map and state encodings for the host port
package ihid_pkg;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 100; // 10 MHz system clock
  localparam int PRT_PULSE_NS = 500; // Low time of a shared printer interrupt pulse
  localparam int PRT_PULSE_CYC = (PRT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PRT_PULSE_CNT = 4'(PRT_PULSE_CYC); // Counter load value

  // ==========================================
  // Address map
  localparam logic [9:0] FDC_BASE = 10'h3F0; // Floppy register block
  localparam logic [9:0] COM1_BASE = 10'h3F8;
  localparam logic [9:0] COM2_BASE = 10'h2F8;
  localparam logic [9:0] COM3_BASE = 10'h3E8;
  localparam logic [9:0] COM4_BASE = 10'h2E8;
  localparam logic [9:0] PRT_BASE_378 = 10'h378;
  localparam logic [9:0] PRT_BASE_278 = 10'h278;
  localparam logic [9:0] PRT_BASE_3BC = 10'h3BC;
  localparam logic [9:0] MASK_8_REG = 10'h3F8; // Eight-register block
  localparam logic [9:0] MASK_4_REG = 10'h3FC; // Four-register block

  // ==========================================
  // Select codes
  localparam logic [1:0] COM_SEL_1 = 2'h0;
  localparam logic [1:0] COM_SEL_2 = 2'h1;
  localparam logic [1:0] COM_SEL_3 = 2'h2;
  localparam logic [1:0] COM_SEL_4 = 2'h3;
  localparam logic [1:0] PRT_SEL_378 = 2'h0;
  localparam logic [1:0] PRT_SEL_278 = 2'h1;
  localparam logic [1:0] PRT_SEL_3BC = 2'h2;

  // ==========================================
  // Control fields and reset values
  localparam int CTRL_IRQ_EN_BIT = 3; // Primary serial interrupt drive enable
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] SEL_NONE = 4'h0;

  // DMA transfer tracker states
  typedef enum logic [2:0] {
    IHID_DMA_IDLE = 3'b001,
    IHID_DMA_XFER = 3'b010,
    IHID_DMA_DONE = 3'b100
  } ihid_dma_state_e;

  // Base address of a serial port from its COM select
  function automatic logic [9:0] ihid_com_base(input logic [1:0] sel);
    case (sel)
      COM_SEL_1: ihid_com_base = COM1_BASE;
      COM_SEL_2: ihid_com_base = COM2_BASE;
      COM_SEL_3: ihid_com_base = COM3_BASE;
      default: ihid_com_base = COM4_BASE;
    endcase
  endfunction : ihid_com_base
endpackage : ihid_pkg

// *** verilog/ihid_com_route.sv ***
// Steers one serial port interrupt onto the primary or secondary line
`timescale 1ns/1ps
module ihid_com_route
  import ihid_pkg::*;
(
  input wire logic [1:0] com_sel, // COM slot the port occupies
  input wire logic irq, // Port interrupt request
  output logic to_primary, // Contribution to primary line
  output logic to_secondary // Contribution to secondary line
);
  // ==========================================
  // Slot decode
  wire is_odd_slot = (com_sel == COM_SEL_1) || (com_sel == COM_SEL_3);

  assign to_primary = irq & is_odd_slot; // RULE9
  assign to_secondary = irq & ~is_odd_slot; // RULE10
endmodule : ihid_com_route

// *** verilog/ihid_host_port.sv ***
// Host I/O decode, interrupt routing and floppy DMA handshake
//
// Summary of operation
// [RULE1] Master reset input high resets everything
// [RULE2] Eight data bits, ten address bits decoded
// [RULE3] Address bit ten selects ECP high group
// [RULE4] EPP mode holds channel ready low
// [RULE5] Floppy DMA request follows controller need
// [RULE6] DMA acknowledge replaces decoded register access
// [RULE7] Terminal count ends floppy DMA operation
// [RULE8] Floppy interrupt on its own output
// [RULE9] COM1/COM3 port interrupt to primary line
// [RULE10] COM2/COM4 port interrupt to secondary line
// [RULE11] Control bit three clear floats primary
// [RULE12] Primary line floats after every reset
// [RULE13] Printer base 378h, 278h or 3BCh
// [RULE14] Write protect forces drive write inactive
// [RULE15] EPP/ECP printer interrupt pulses low, releases
// [RULE16] Address enable high blocks register strobes
// [RULE17] Drive data on decoded read, latch writes
`timescale 1ns/1ps
module ihid_host_port
  import ihid_pkg::*;
(
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic master_reset_in, // Master reset, active high
  input wire logic [9:0] addr, // Host address bits 0 to 9
  input wire logic addr_a10, // Host address bit 10
  input wire logic aen, // Address enable, high in DMA cycles
  input wire logic ior_n, // Host read strobe
  input wire logic iow_n, // Host write strobe
  input wire logic [7:0] data_in, // Host data bus, input side
  output logic [7:0] data_out, // Host data bus, output side
  output logic data_oe, // Host data bus drive enable
  output logic [3:0] reg_sel, // One-hot: printer, port B, port A, floppy
  output logic [2:0] reg_offset, // Register offset in the block
  output logic reg_high_group, // ECP high register group
  output logic reg_write_pulse, // One cycle after write strobe falls
  output logic [7:0] reg_write_data, // Latched write data
  output logic dma_cycle, // DMA transfer strobe in progress
  input wire logic [7:0] func_read_data, // Read data from functions
  input wire logic [7:0] host_control_register, // Host control byte
  input wire logic [1:0] uart_a_com_sel, // COM slot of port A
  input wire logic [1:0] uart_b_com_sel, // COM slot of port B
  input wire logic [1:0] prt_base_sel, // Printer base select
  input wire logic epp_mode, // Enhanced parallel mode
  input wire logic ecp_mode, // Extended capabilities mode
  input wire logic epp_busy, // Parallel transfer not complete
  output logic channel_ready_out, // Channel ready, open drain level
  output logic channel_ready_oe, // Channel ready pull-down enable
  input wire logic fdc_dma_need, // Floppy controller wants DMA
  output logic floppy_dma_request, // Floppy DMA request
  input wire logic floppy_dma_acknowledge_n, // Floppy DMA acknowledge
  input wire logic terminal_count, // Final DMA transfer mark
  output logic dma_xfer_done, // Pulse after each DMA transfer
  output logic dma_terminated, // Pulse when DMA ends on terminal count
  input wire logic fdc_irq, // Floppy interrupt request
  input wire logic uart_a_irq, // Port A interrupt request
  input wire logic uart_b_irq, // Port B interrupt request
  input wire logic prt_irq, // Printer interrupt request
  output logic floppy_interrupt_out, // Floppy interrupt line
  output logic primary_serial_interrupt_out, // Primary serial line
  output logic primary_serial_interrupt_oe, // Primary serial drive enable
  output logic secondary_serial_interrupt_out, // Secondary serial line
  output logic printer_interrupt_out, // Printer interrupt line
  output logic printer_interrupt_oe, // Printer interrupt drive enable
  input wire logic write_protect, // Software write protect active
  input wire logic fdd_write_gate_in_n, // Drive write enable from controller
  input wire logic fdd_write_data_in_n, // Drive write data from controller
  output logic fdd_write_gate_n, // Drive write enable pin
  output logic fdd_write_data_n // Drive write data pin
);
  // ==========================================
  // Address decode
  wire dack_act = ~floppy_dma_acknowledge_n; // Acknowledge asserted
  wire cyc_ok = ~aen & ~dack_act; // RULE16 RULE6
  wire strobe_any = ~ior_n | ~iow_n; // Either strobe low
  wire [9:0] prt_base = (prt_base_sel == PRT_SEL_278) ? PRT_BASE_278 :
                        (prt_base_sel == PRT_SEL_3BC) ? PRT_BASE_3BC : PRT_BASE_378; // RULE13
  wire [9:0] prt_mask = (prt_base_sel == PRT_SEL_3BC) ? MASK_4_REG : MASK_8_REG;
  wire prt_match = (addr & prt_mask) == prt_base; // RULE2
  wire prt_hit = prt_match; // Low and high groups both decode
  wire prt_high = ecp_mode & addr_a10 & prt_match; // RULE3
  wire ua_hit = (addr & MASK_8_REG) == ihid_com_base(uart_a_com_sel);
  wire ub_hit = (addr & MASK_8_REG) == ihid_com_base(uart_b_com_sel);
  wire fdc_hit = ((addr & MASK_8_REG) == FDC_BASE) & (~addr_a10 | ~ecp_mode);
  wire [3:0] hit_vec = {prt_hit, ub_hit & ~prt_hit, ua_hit & ~prt_hit, fdc_hit};
  wire any_hit = |hit_vec;
  wire dec_access = cyc_ok & any_hit & strobe_any; // Decoded register access
  wire [3:0] sel_d = dec_access ? hit_vec : SEL_NONE;

  // Data bus drive, decoded read or DMA read
  assign data_oe = ~ior_n & ((cyc_ok & any_hit) | dack_act); // RULE17

  // ==========================================
  // Strobe edge and register select flops
  logic iow_q; // Previous write strobe
  logic [3:0] sel_q; // Registered select
  logic [2:0] off_q; // Registered offset
  logic high_q; // Registered high group
  logic wr_q; // Write pulse
  logic [7:0] wdat_q; // Write data
  logic [7:0] rdat_q; // Read data toward host
  wire iow_fall = iow_q & ~iow_n; // Write strobe falling edge
  wire wr_take = iow_fall & ((cyc_ok & any_hit) | dack_act);

  // Select, offset and write capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      iow_q <= 1'b1;
      sel_q <= SEL_NONE;
      off_q <= 3'h0;
      high_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= DATA_RST;
      rdat_q <= DATA_RST;
    end else if (master_reset_in) begin // RULE1
      iow_q <= 1'b1;
      sel_q <= SEL_NONE;
      off_q <= 3'h0;
      high_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= DATA_RST;
      rdat_q <= DATA_RST;
    end else begin
      iow_q <= iow_n;
      sel_q <= sel_d; // RULE6
      off_q <= addr[2:0];
      high_q <= prt_high & dec_access; // RULE3
      wr_q <= wr_take; // RULE17
      wdat_q <= wr_take ? data_in : wdat_q; // RULE17
      rdat_q <= func_read_data;
    end
  end

  assign reg_sel = sel_q;
  assign reg_offset = off_q;
  assign reg_high_group = high_q;
  assign reg_write_pulse = wr_q;
  assign reg_write_data = wdat_q;
  assign data_out = rdat_q;
  assign dma_cycle = dack_act & strobe_any;

  // ==========================================
  // Channel ready stretch in enhanced parallel mode
  assign channel_ready_out = 1'b0; // Open drain only pulls low
  assign channel_ready_oe = epp_mode & prt_hit & dec_access & epp_busy; // RULE4

  // ==========================================
  // Floppy DMA handshake
  ihid_dma_state_e st_q; // Transfer tracker
  ihid_dma_state_e st_d;
  logic tc_seen_q; // Terminal count seen in transfer
  logic tc_block_q; // Holds request off after terminal count
  logic drq_q; // Request flop
  logic done_q; // Transfer done pulse
  logic term_q; // Terminated pulse
  wire xfer_end = (st_q == IHID_DMA_XFER) & ior_n & iow_n;
  wire tc_now = dack_act & terminal_count;

  // Next state of the tracker
  always_comb begin
    st_d = st_q;
    case (st_q)
      IHID_DMA_IDLE: st_d = (dack_act & strobe_any) ? IHID_DMA_XFER : IHID_DMA_IDLE;
      IHID_DMA_XFER: st_d = xfer_end ? IHID_DMA_DONE : IHID_DMA_XFER;
      IHID_DMA_DONE: st_d = IHID_DMA_IDLE;
      default: st_d = IHID_DMA_IDLE;
    endcase
  end

  // Tracker, request and terminal count flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= IHID_DMA_IDLE;
      tc_seen_q <= 1'b0;
      tc_block_q <= 1'b0;
      drq_q <= 1'b0;
      done_q <= 1'b0;
      term_q <= 1'b0;
    end else if (master_reset_in) begin // RULE1
      st_q <= IHID_DMA_IDLE;
      tc_seen_q <= 1'b0;
      tc_block_q <= 1'b0;
      drq_q <= 1'b0;
      done_q <= 1'b0;
      term_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tc_seen_q <= (st_q == IHID_DMA_XFER) ? (tc_seen_q | tc_now) : tc_now;
      tc_block_q <= tc_now | (tc_block_q & fdc_dma_need); // RULE7
      drq_q <= fdc_dma_need & ~tc_block_q & ~tc_now; // RULE5 RULE7
      done_q <= xfer_end;
      term_q <= xfer_end & (tc_seen_q | tc_now); // RULE7
    end
  end

  assign floppy_dma_request = drq_q;
  assign dma_xfer_done = done_q;
  assign dma_terminated = term_q;

  // ==========================================
  // Interrupt routing
  logic a_pri; // Port A to primary
  logic a_sec; // Port A to secondary
  logic b_pri; // Port B to primary
  logic b_sec; // Port B to secondary

  ihid_com_route u_route_a (
    .com_sel(uart_a_com_sel),
    .irq(uart_a_irq),
    .to_primary(a_pri),
    .to_secondary(a_sec)
  );

  ihid_com_route u_route_b (
    .com_sel(uart_b_com_sel),
    .irq(uart_b_irq),
    .to_primary(b_pri),
    .to_secondary(b_sec)
  );

  logic fint_q; // Floppy interrupt
  logic pint_q; // Primary serial level
  logic pen_q; // Primary drive enable
  logic sint_q; // Secondary serial level
  logic prt_q; // Previous printer request
  logic [3:0] pcnt_q; // Printer pulse counter
  logic wg_q; // Drive write enable pin
  logic wd_q; // Drive write data pin
  wire pulse_mode = epp_mode | ecp_mode; // Shared pulse signalling
  wire prt_start = pulse_mode & prt_irq & ~prt_q & (pcnt_q == 4'h0);

  // Interrupt lines, printer pulse and write protect
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fint_q <= 1'b0;
      pint_q <= 1'b0;
      pen_q <= 1'b0;
      sint_q <= 1'b0;
      prt_q <= 1'b0;
      pcnt_q <= 4'h0;
      wg_q <= 1'b1;
      wd_q <= 1'b1;
    end else if (master_reset_in) begin // RULE1 RULE12
      fint_q <= 1'b0;
      pint_q <= 1'b0;
      pen_q <= 1'b0;
      sint_q <= 1'b0;
      prt_q <= 1'b0;
      pcnt_q <= 4'h0;
      wg_q <= 1'b1;
      wd_q <= 1'b1;
    end else begin
      fint_q <= fdc_irq; // RULE8
      pint_q <= a_pri | b_pri; // RULE9
      pen_q <= host_control_register[CTRL_IRQ_EN_BIT]; // RULE11 RULE12
      sint_q <= a_sec | b_sec; // RULE10
      prt_q <= prt_irq;
      pcnt_q <= prt_start ? PRT_PULSE_CNT : (pcnt_q != 4'h0) ? pcnt_q - 4'h1 : pcnt_q; // RULE15
      wg_q <= write_protect | fdd_write_gate_in_n; // RULE14
      wd_q <= write_protect | fdd_write_data_in_n; // RULE14
    end
  end

  assign floppy_interrupt_out = fint_q;
  assign primary_serial_interrupt_out = pint_q;
  assign primary_serial_interrupt_oe = pen_q;
  assign secondary_serial_interrupt_out = sint_q;
  assign printer_interrupt_out = pulse_mode ? 1'b0 : prt_q; // RULE15
  assign printer_interrupt_oe = pulse_mode ? (pcnt_q != 4'h0) : 1'b1; // RULE15
  assign fdd_write_gate_n = wg_q;
  assign fdd_write_data_n = wd_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || master_reset_in);

  // Start of a shared printer pulse
  sequence s_prt_fire;
    pulse_mode && prt_irq && !prt_q && (pcnt_q == 4'h0);
  endsequence

  // Five cycles pulled low, then released
  sequence s_prt_low;
    (printer_interrupt_oe && !printer_interrupt_out) [*5] ##1 !printer_interrupt_oe;
  endsequence

  // Last transfer closing with terminal count
  sequence s_tc_last;
    (st_q == IHID_DMA_XFER) && tc_now && ior_n && iow_n;
  endsequence

  // Terminated pulse, then request withdrawn
  sequence s_tc_close;
    dma_terminated ##1 !floppy_dma_request;
  endsequence

  chk_aen_blocks_wr: assert property ( // RULE16
    (iow_fall && aen && !dack_act) |=> !reg_write_pulse)
    else $error("write pulse during address enable");
  chk_data_drive: assert property ( // RULE17
    data_oe |-> (!ior_n && (dack_act || (cyc_ok && any_hit))))
    else $error("data bus driven outside read");
  chk_wr_latch: assert property ( // RULE17
    (iow_fall && cyc_ok && any_hit) |=>
    (reg_write_pulse && reg_write_data == $past(data_in)))
    else $error("write data not latched");
  chk_pri_irq_float: assert property ( // RULE11
    !host_control_register[CTRL_IRQ_EN_BIT] |=> !primary_serial_interrupt_oe)
    else $error("primary serial driven while disabled");
  chk_fdc_irq_follow: assert property ( // RULE8
    fdc_irq |=> floppy_interrupt_out)
    else $error("floppy interrupt not presented");
  chk_drq_follow: assert property ( // RULE5
    (fdc_dma_need && !tc_block_q && !tc_now) |=> floppy_dma_request)
    else $error("floppy DMA request missing");
  chk_tc_end: assert property ( // RULE7
    s_tc_last |=> s_tc_close)
    else $error("DMA not ended on terminal count");
  chk_dack_sel: assert property ( // RULE6
    dack_act |=> (reg_sel == SEL_NONE))
    else $error("register selected during DMA acknowledge");
  chk_prt_pulse: assert property ( // RULE15
    s_prt_fire |=> s_prt_low)
    else $error("printer pulse wrong length");
  chk_chrdy_hold: assert property ( // RULE4
    (epp_mode && dec_access && prt_hit && epp_busy) |-> channel_ready_oe)
    else $error("channel ready not pulled low");
  chk_wp_force: assert property ( // RULE14
    write_protect |=> (fdd_write_gate_n && fdd_write_data_n))
    else $error("drive write not forced inactive");
  chk_ecp_high: assert property ( // RULE3
    (ecp_mode && addr_a10 && prt_match && dec_access) |=> reg_high_group)
    else $error("ECP high group not decoded");
endmodule : ihid_host_port

// *** sim/ihid_host_model.sv ***
// Host I/O bus and floppy DMA controller model
`timescale 1ns/1ps
module ihid_host_model (
  input wire logic clock,
  output logic [9:0] addr,
  output logic addr_a10,
  output logic aen,
  output logic ior_n,
  output logic iow_n,
  output logic [7:0] data_in,
  output logic floppy_dma_acknowledge_n,
  output logic terminal_count
);
  // ==========================================
  // Idle bus from time zero
  initial begin
    addr = 10'h000;
    addr_a10 = 1'b0;
    aen = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    data_in = 8'h00;
    floppy_dma_acknowledge_n = 1'b1;
    terminal_count = 1'b0;
  end

  // Open one read or write; a DMA cycle when dk is set
  task automatic start(input logic [9:0] a, input logic hi, input logic wr,
                       input logic [7:0] d, input logic ae, input logic dk);
    @(posedge clock);
    addr <= a;
    addr_a10 <= hi;
    aen <= ae;
    floppy_dma_acknowledge_n <= !dk;
    data_in <= wr ? d : ~data_in;
    iow_n <= !wr;
    ior_n <= wr;
  endtask : start

  // Raise strobes, mark the last transfer, then release the bus
  task automatic stop(input logic last);
    @(posedge clock);
    iow_n <= 1'b1;
    ior_n <= 1'b1;
    terminal_count <= last;
    @(posedge clock);
    terminal_count <= 1'b0;
    floppy_dma_acknowledge_n <= 1'b1;
    aen <= 1'b0;
    data_in <= ~data_in; // Released bus shows no stale byte
  endtask : stop
endmodule : ihid_host_model

// *** sim/tb_top.sv ***
// Self-checking bench for the host port block
`timescale 1ns/1ps
module tb_top
  import ihid_pkg::*;
;
  // ==========================================
  // Signals
  logic clock, rst_n, master_reset_in, addr_a10, aen, ior_n, iow_n;
  logic [9:0] addr;
  logic [7:0] data_in, data_out, reg_write_data, func_read_data, host_control_register;
  logic data_oe, reg_high_group, reg_write_pulse, dma_cycle, channel_ready_out;
  logic [3:0] reg_sel;
  logic [2:0] reg_offset;
  logic [1:0] uart_a_com_sel, uart_b_com_sel, prt_base_sel;
  logic epp_mode, ecp_mode, epp_busy, channel_ready_oe, fdc_dma_need, floppy_dma_request;
  logic floppy_dma_acknowledge_n, terminal_count, dma_xfer_done, dma_terminated;
  logic fdc_irq, uart_a_irq, uart_b_irq, prt_irq, floppy_interrupt_out;
  logic primary_serial_interrupt_out, primary_serial_interrupt_oe;
  logic secondary_serial_interrupt_out, printer_interrupt_out, printer_interrupt_oe;
  logic write_protect, fdd_write_gate_in_n, fdd_write_data_in_n;
  logic fdd_write_gate_n, fdd_write_data_n;
  int err_total, checks_done, cycles, n_wr, n_done, n_term;

  ihid_host_port ihid_host_port_i (.*);
  ihid_host_model ihid_host_model_i (.*);

  // ==========================================
  // Clock, pulse counters and hang limit
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    n_wr += (reg_write_pulse === 1'b1);
    n_done += (dma_xfer_done === 1'b1);
    n_term += (dma_terminated === 1'b1);
    if (cycles == 3000) begin
      err_total++;
      conclude();
    end
  end

  // ==========================================
  // Shared helpers
  task automatic compare(input logic [7:0] seen, input logic [7:0] want, input string m);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: %s saw %h want %h", $time, m, seen, want);
    end
  endtask : compare
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic conclude;
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // One host access and its decode outcome
  task automatic bus(input logic [9:0] a, input logic wr, input logic [7:0] d,
                     input logic ae, input logic [3:0] sel);
    int w;
    w = n_wr;
    ihid_host_model_i.start(a, 1'b0, wr, d, ae, 1'b0);
    #1;
    compare(data_oe, !wr && sel != 4'h0, "drive");
    tick(1);
    compare(reg_sel, sel, "select");
    if (sel != 4'h0) compare(reg_offset, a[2:0], "offset");
    if (!wr) compare(data_out, func_read_data, "rdata");
    ihid_host_model_i.stop(1'b0);
    tick(2);
    compare(n_wr - w, wr && sel != 4'h0, "wpulse");
    if (wr && sel != 4'h0) compare(reg_write_data, d, "wdata");
  endtask : bus

  // ==========================================
  // Scenarios
  task automatic t_reset;
    tick(1);
    compare(primary_serial_interrupt_oe, 0, "oe rst");
    compare(floppy_dma_request, 0, "drq rst");
    @(posedge clock);
    host_control_register <= 8'h08;
    tick(2);
    compare(primary_serial_interrupt_oe, 1, "oe on");
    @(posedge clock);
    master_reset_in <= 1'b1;
    tick(2);
    compare(primary_serial_interrupt_oe, 0, "oe mr");
    @(posedge clock);
    master_reset_in <= 1'b0;
    tick(2);
    compare(primary_serial_interrupt_oe, 1, "oe after");
  endtask : t_reset
  task automatic t_decode;
    logic [9:0] base [3];
    base = '{PRT_BASE_378, PRT_BASE_278, PRT_BASE_3BC};
    for (int s = 0; s < 3; s++) begin
      @(posedge clock);
      prt_base_sel <= 2'(s);
      bus(base[s] + 10'h001, 1'b1, 8'hA0 + 8'(s), 1'b0, 4'h8);
    end
    @(posedge clock);
    func_read_data <= 8'h5C;
    bus(FDC_BASE + 10'h002, 1'b0, 8'h00, 1'b0, 4'h1);
    bus(COM1_BASE + 10'h003, 1'b1, 8'h11, 1'b0, 4'h2);
    bus(COM2_BASE, 1'b0, 8'h00, 1'b0, 4'h4);
    bus(10'h100, 1'b0, 8'h00, 1'b0, 4'h0);
    bus(base[2], 1'b1, 8'h33, 1'b1, 4'h0);
    bus(FDC_BASE, 1'b0, 8'h00, 1'b1, 4'h0);
  endtask : t_decode
  task automatic t_dma;
    int d;
    int t;
    @(posedge clock);
    fdc_dma_need <= 1'b1;
    tick(2);
    compare(floppy_dma_request, 1, "drq");
    d = n_done;
    t = n_term;
    ihid_host_model_i.start(10'h000, 1'b0, 1'b1, 8'h77, 1'b1, 1'b1);
    #1;
    compare(dma_cycle, 1, "dma cyc");
    tick(1);
    compare(reg_sel, 0, "dma sel");
    ihid_host_model_i.stop(1'b0);
    ihid_host_model_i.start(10'h000, 1'b0, 1'b0, 8'h00, 1'b1, 1'b1);
    #1;
    compare(data_oe, 1, "dma drive");
    ihid_host_model_i.stop(1'b1);
    tick(3);
    compare(n_done - d, 2, "xfers");
    compare(n_term - t, 1, "term");
    compare(floppy_dma_request, 0, "drq end");
    @(posedge clock);
    fdc_dma_need <= 1'b0;
  endtask : t_dma
  task automatic t_irq;
    logic p;
    for (int s = 0; s < 8; s++) begin
      @(posedge clock);
      uart_a_com_sel <= s[1:0];
      uart_b_com_sel <= s[1:0];
      uart_a_irq <= !s[2];
      uart_b_irq <= s[2];
      fdc_irq <= s[0];
      tick(2);
      p = (s[1:0] == COM_SEL_1) || (s[1:0] == COM_SEL_3);
      compare(primary_serial_interrupt_out, p, "pri");
      compare(secondary_serial_interrupt_out, !p, "sec");
      compare(floppy_interrupt_out, s[0], "fdc");
    end
    @(posedge clock);
    host_control_register <= 8'h00;
    tick(2);
    compare(primary_serial_interrupt_oe, 0, "oe off");
  endtask : t_irq
  task automatic t_par;
    int n;
    @(posedge clock);
    prt_base_sel <= PRT_SEL_378;
    epp_mode <= 1'b1;
    epp_busy <= 1'b1;
    ihid_host_model_i.start(PRT_BASE_378 + 10'h004, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    tick(1);
    compare(channel_ready_oe, 1, "rdy hold");
    compare(channel_ready_out, 0, "rdy low");
    @(posedge clock);
    epp_busy <= 1'b0;
    #1;
    compare(channel_ready_oe, 0, "rdy free");
    ihid_host_model_i.stop(1'b0);
    @(posedge clock);
    epp_mode <= 1'b0;
    ecp_mode <= 1'b1;
    ihid_host_model_i.start(PRT_BASE_378, 1'b1, 1'b1, 8'h42, 1'b0, 1'b0);
    tick(1);
    compare(reg_high_group, 1, "high grp");
    ihid_host_model_i.stop(1'b0);
    @(posedge clock);
    prt_irq <= 1'b1;
    n = 0;
    repeat (10) begin
      tick(1);
      n += (printer_interrupt_oe === 1'b1 && printer_interrupt_out === 1'b0);
    end
    compare(n, PRT_PULSE_CYC, "pulse");
    compare(printer_interrupt_oe, 0, "released");
    @(posedge clock);
    ecp_mode <= 1'b0;
    tick(1);
    compare({printer_interrupt_oe, printer_interrupt_out}, 2'h3, "spp level");
    @(posedge clock);
    prt_irq <= 1'b0;
    tick(1);
    compare({printer_interrupt_oe, printer_interrupt_out}, 2'h2, "spp idle");
  endtask : t_par
  task automatic t_wp;
    @(posedge clock);
    fdd_write_gate_in_n <= 1'b0;
    fdd_write_data_in_n <= 1'b0;
    tick(2);
    compare({fdd_write_gate_n, fdd_write_data_n}, 2'h0, "wr pass");
    @(posedge clock);
    write_protect <= 1'b1;
    tick(2);
    compare({fdd_write_gate_n, fdd_write_data_n}, 2'h3, "wr block");
  endtask : t_wp

  // ==========================================
  // Main sequence
  initial begin
    {rst_n, master_reset_in, func_read_data, host_control_register, uart_a_com_sel,
     prt_base_sel, epp_mode, ecp_mode, epp_busy, fdc_dma_need, fdc_irq, uart_a_irq,
     uart_b_irq, prt_irq, write_protect} = '0;
    uart_b_com_sel = COM_SEL_2;
    {fdd_write_gate_in_n, fdd_write_data_in_n} = 2'h3;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_decode();
    t_dma();
    t_irq();
    t_par();
    t_wp();
    conclude();
  end
endmodule : tb_top
